// file: hef_event_flags.sv
// link-3 event status flags, interrupt enables and AXI4-Lite slave
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module hef_event_flags (
	input wire logic CLK,
	input wire logic RST,
	input wire hef_pkg::hef_addr_t AWADDR,
	input wire logic AWVALID,
	output var logic AWREADY,
	input wire hef_pkg::hef_data_t WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output var logic WREADY,
	output var logic [1:0] BRESP,
	output var logic BVALID,
	input wire logic BREADY,
	input wire hef_pkg::hef_addr_t ARADDR,
	input wire logic ARVALID,
	output var logic ARREADY,
	output var hef_pkg::hef_data_t RDATA,
	output var logic [1:0] RRESP,
	output var logic RVALID,
	input wire logic RREADY,
	input wire hef_pkg::hef_events_s EVENTS,
	input wire hef_pkg::hef_serial_s RX_LINE,
	output var logic IRQ
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg;
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	hef_pkg::hef_addr_t awaddr_reg;
	hef_pkg::hef_data_t wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_take, w_take, wr_fire;
	hef_pkg::hef_addr_t wr_addr;
	hef_pkg::hef_data_t wr_data;
	logic [3:0] wr_strb;
	logic wr_hit_en, wr_hit_status, en_write;

	hef_pkg::hef_rd_state_e rd_state_reg, rd_state_next;
	logic arready_reg;
	logic rvalid_reg;
	hef_pkg::hef_data_t rdata_reg;
	logic [1:0] rresp_reg;
	logic ar_take, status_read, rd_hit_en;

	hef_pkg::hef_byte_t status_reg, status_next, set_vec;
	hef_pkg::hef_byte_t en_reg, en_next;
	logic irq_reg;

	hef_pkg::hef_byte_t shift_reg, shift_next;
	logic [2:0] ones_reg, ones_next;
	logic abort_hit, octet_hit;

	// --------------------------------------------------------------
	// write channels
	// --------------------------------------------------------------
	// address and data may arrive in either order; each is parked until
	// its partner shows up so the write happens exactly once
	always_comb begin
		aw_take = AWVALID & awready_reg;
		w_take = WVALID & wready_reg;
		wr_addr = aw_held_reg ? awaddr_reg : AWADDR;
		wr_data = w_held_reg ? wdata_reg : WDATA;
		wr_strb = w_held_reg ? wstrb_reg : WSTRB;
		wr_fire = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~bvalid_reg;
		aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
		w_held_next = (w_held_reg | w_take) & ~wr_fire;
		bvalid_next = wr_fire | (bvalid_reg & ~BREADY);
		awready_next = ~aw_held_next & ~bvalid_next;
		wready_next = ~w_held_next & ~bvalid_next;
		wr_hit_en = wr_addr[7:2] == hef_pkg::OFF_IRQ_EN[7:2];
		wr_hit_status = wr_addr[7:2] == hef_pkg::OFF_STATUS[7:2];
		en_write = wr_fire & wr_hit_en & wr_strb[0];
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= hef_pkg::RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			if (aw_take) begin
				awaddr_reg <= AWADDR;
			end
			if (w_take) begin
				wdata_reg <= WDATA;
				wstrb_reg <= WSTRB;
			end
			// writes to the status word are accepted and dropped
			if (wr_fire) begin
				bresp_reg <= (wr_hit_en | wr_hit_status) ? hef_pkg::RESP_OKAY
					: hef_pkg::RESP_SLVERR;
			end
		end
	end

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	always_comb begin
		ar_take = ARVALID & arready_reg;
		rd_hit_en = ARADDR[7:2] == hef_pkg::OFF_IRQ_EN[7:2];
		status_read = ar_take & (ARADDR[7:2] == hef_pkg::OFF_STATUS[7:2]);
		case (rd_state_reg)
			hef_pkg::HEF_RD_IDLE: begin
				rd_state_next = ar_take ? hef_pkg::HEF_RD_RESP : hef_pkg::HEF_RD_IDLE;
			end
			hef_pkg::HEF_RD_RESP: begin
				rd_state_next = RREADY ? hef_pkg::HEF_RD_IDLE : hef_pkg::HEF_RD_RESP;
			end
			default: begin
				rd_state_next = hef_pkg::HEF_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_state_reg <= hef_pkg::HEF_RD_IDLE;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= hef_pkg::RESP_OKAY;
		end else begin
			rd_state_reg <= rd_state_next;
			arready_reg <= rd_state_next == hef_pkg::HEF_RD_IDLE;
			rvalid_reg <= rd_state_next == hef_pkg::HEF_RD_RESP;
			if (ar_take) begin
				// status captured before clearing; a flag set this cycle survives
				if (status_read) begin
					rdata_reg <= {24'h000000, status_reg};
					rresp_reg <= hef_pkg::RESP_OKAY;
				end else if (rd_hit_en) begin
					rdata_reg <= {24'h000000, en_reg};
					rresp_reg <= hef_pkg::RESP_OKAY;
				end else begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= hef_pkg::RESP_SLVERR;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// flag octet and abort detection on the incoming link
	// --------------------------------------------------------------
	always_comb begin
		shift_next = shift_reg;
		ones_next = ones_reg;
		if (RX_LINE.valid) begin
			shift_next = {shift_reg[6:0], RX_LINE.data};
			if (!RX_LINE.data) begin
				ones_next = 3'h0;
			end else if (ones_reg != hef_pkg::ONES_SAT) begin
				ones_next = ones_reg + 3'h1;
			end
		end
		// fires once on the seventh one of a run, not on each later one
		abort_hit = RX_LINE.valid & RX_LINE.data
			& (ones_reg == hef_pkg::ONES_BEFORE_ABORT);
		octet_hit = RX_LINE.valid & (shift_next == hef_pkg::FLAG_OCTET);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			shift_reg <= 8'h00;
			ones_reg <= 3'h0;
		end else begin
			shift_reg <= shift_next;
			ones_reg <= ones_next;
		end
	end

	// --------------------------------------------------------------
	// status flags
	// --------------------------------------------------------------
	always_comb begin
		set_vec = 8'h00;
		set_vec[hef_pkg::BIT_TX_BEGIN] = EVENTS.tx_begin;
		set_vec[hef_pkg::BIT_RX_BEGIN] = EVENTS.rx_begin;
		set_vec[hef_pkg::BIT_TX_FINISH] = EVENTS.tx_finish;
		set_vec[hef_pkg::BIT_RX_FINISH] = EVENTS.rx_msg_done | EVENTS.rx_buf_full;
		set_vec[hef_pkg::BIT_FCS_FAULT] = EVENTS.fcs_fault;
		set_vec[hef_pkg::BIT_ABORT] = abort_hit;
		// closing flag of a whole message reports both; a full buffer only the end flag
		set_vec[hef_pkg::BIT_IDLE] = octet_hit | EVENTS.rx_msg_done;
		// set beats the read clear so no event is lost
		status_next = ((status_reg & ~({8{status_read}})) | set_vec)
			& hef_pkg::STATUS_MASK;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			status_reg <= hef_pkg::STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// --------------------------------------------------------------
	// interrupt enables and output
	// --------------------------------------------------------------
	always_comb begin
		en_next = en_reg;
		if (en_write) begin
			en_next = wr_data[7:0] & hef_pkg::IRQ_EN_RW_MASK;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			en_reg <= hef_pkg::IRQ_EN_RESET;
			irq_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			// enable bits 6..3 line up with their flags
			irq_reg <= |(status_next & en_next);
		end
	end

	assign AWREADY = awready_reg;
	assign WREADY = wready_reg;
	assign BVALID = bvalid_reg;
	assign BRESP = bresp_reg;
	assign ARREADY = arready_reg;
	assign RVALID = rvalid_reg;
	assign RDATA = rdata_reg;
	assign RRESP = rresp_reg;
	assign IRQ = irq_reg;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	logic any_set;
	assign any_set = |set_vec;

	sequence s_quiet_read;
		status_read && !any_set;
	endsequence

	sequence s_flags_cleared;
		status_reg == 8'h00 ##0 !IRQ;
	endsequence

	a_eom_on_done: assert property (EVENTS.rx_msg_done |=> status_reg[3] && status_reg[0])
		else $error("message done did not set end and idle flags");
	a_eom_on_full: assert property (EVENTS.rx_buf_full |=> status_reg[3])
		else $error("buffer full did not set end flag");
	a_fcs_flag_set: assert property (EVENTS.fcs_fault |=> status_reg[2])
		else $error("frame check fault not flagged");
	a_abort_run_seen: assert property ((ones_reg == 3'h6 && RX_LINE.valid && RX_LINE.data)
		|=> status_reg[1])
		else $error("seventh one did not set abort flag");
	a_flag_octet_seen: assert property ((RX_LINE.valid
		&& {shift_reg[6:0], RX_LINE.data} == 8'h7E) |=> status_reg[0])
		else $error("flag octet not flagged");
	a_tx_begin_flag: assert property (EVENTS.tx_begin |=> status_reg[6] [*1] ##0 status_reg[7] == 1'b0)
		else $error("transmit start not flagged");
	a_read_clears_all: assert property (s_quiet_read |=> s_flags_cleared)
		else $error("status read did not clear flags and interrupt");
	a_flag_sticks_on: assert property ((status_reg[4] && !status_read) |=> status_reg[4])
		else $error("flag dropped without a read");
	a_irq_follows_en: assert property (((|(status_reg & en_reg)) && !status_read && !en_write)
		|=> IRQ)
		else $error("enabled flag did not raise interrupt");
	// only flags 6..3 have enables, so the low flags can never raise the line
	a_irq_needs_en: assert property (IRQ |-> (|(status_reg[6:3] & en_reg[6:3])))
		else $error("interrupt without an enabled flag");
	a_en_reset_zero: assert property ($fell(RST) |-> en_reg == 8'h00)
		else $error("enables not cleared by reset");
	a_en_bit7_zero: assert property (en_reg[7] == 1'b0 && en_reg[2:0] == 3'h0)
		else $error("reserved enable bits set");
	a_rdata_held: assert property ((RVALID && !RREADY) |=> RVALID && $stable(RDATA))
		else $error("read answer changed before taken");

	// independent views of the abort, idle and end flags' causes
	logic run_seventh, octet_now, idle_cause, eom_cause;
	logic [6:3] irq_armed;
	assign run_seventh = RX_LINE.valid & RX_LINE.data
		& (ones_reg == hef_pkg::ONES_BEFORE_ABORT);
	assign octet_now = RX_LINE.valid
		& ({shift_reg[6:0], RX_LINE.data} == hef_pkg::FLAG_OCTET);
	assign idle_cause = octet_now | EVENTS.rx_msg_done;
	assign eom_cause = EVENTS.rx_msg_done | EVENTS.rx_buf_full;
	// an enable write in the same cycle may turn the bit off
	assign irq_armed = en_reg[6:3] & {4{~en_write}};

	a_tx_start_irq: assert property (EVENTS.tx_begin && irq_armed[6] |=> IRQ)
		else $error("enabled transmit start did not interrupt");
	a_rx_start_irq: assert property (EVENTS.rx_begin && irq_armed[5] |=> IRQ)
		else $error("enabled receive start did not interrupt");
	a_tx_end_irq: assert property (EVENTS.tx_finish && irq_armed[4] |=> IRQ)
		else $error("enabled transmit end did not interrupt");
	a_rx_end_irq: assert property (EVENTS.rx_msg_done && irq_armed[3] |=> IRQ)
		else $error("enabled receive end did not interrupt");
	a_irq_off_idle: assert property (en_reg == 8'h00 && !en_write |=> !IRQ)
		else $error("interrupt raised with every enable off");
	a_abort_no_false: assert property (!status_reg[1] && !run_seventh |=> !status_reg[1])
		else $error("abort flag set without seven ones");
	a_idle_no_false: assert property (!status_reg[0] && !idle_cause |=> !status_reg[0])
		else $error("idle flag set without its cause");
	a_eom_no_false: assert property (!status_reg[3] && !eom_cause |=> !status_reg[3])
		else $error("end flag set without its cause");
	a_read_flags: assert property (status_read |=> RDATA[7:0] == $past(status_reg))
		else $error("status read did not return the flags");
	a_en_write: assert property (en_write |=> en_reg[6:3] == $past(wr_data[6:3]))
		else $error("enable write did not land");
	a_rx_begin_flag: assert property (EVENTS.rx_begin |=> status_reg[5])
		else $error("receive start not flagged");
	a_tx_finish_flag: assert property (EVENTS.tx_finish |=> status_reg[4])
		else $error("transmit end not flagged");

	// answers come one cycle after the completing handshake
	a_rd_answer_next: assert property (ar_take |=> RVALID)
		else $error("read answer not one cycle after address");
	a_wr_answer_next: assert property (wr_fire |=> BVALID)
		else $error("write answer not one cycle after data");

endmodule

`default_nettype wire

// file: hef_pkg.sv
// constants and carrier types for the link-3 event flag and interrupt enable block
//
// Overview of operation
// - end-of-message flag on message done or buffer full
// - frame-check fault flag on FCS mismatch
// - abort flag on seven consecutive ones
// - idle flag on flag octet 0x7E
// - idle and end flags together mark message
// - status flags sticky, cleared by status read
// - enable bit 6 gates transmit-start interrupt
// - enable bit 5 gates receive-start interrupt
// - enable bit 4 gates transmit-end interrupt
// - enable bit 3 gates receive-end interrupt
// - enable bit 7 reserved, bits 6-3 reset 0
// - transmit-start flag at bit 6
package hef_pkg;

	typedef logic [7:0] hef_addr_t;
	typedef logic [31:0] hef_data_t;
	typedef logic [7:0] hef_byte_t;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam hef_addr_t OFF_IRQ_EN = 8'h00;
	localparam hef_addr_t OFF_STATUS = 8'h04;

	localparam int BIT_TX_BEGIN = 6;
	localparam int BIT_RX_BEGIN = 5;
	localparam int BIT_TX_FINISH = 4;
	localparam int BIT_RX_FINISH = 3;
	localparam int BIT_FCS_FAULT = 2;
	localparam int BIT_ABORT = 1;
	localparam int BIT_IDLE = 0;

	localparam hef_byte_t STATUS_RESET = 8'h00;
	localparam hef_byte_t STATUS_MASK = 8'h7F;
	localparam hef_byte_t IRQ_EN_RESET = 8'h00;
	localparam hef_byte_t IRQ_EN_RW_MASK = 8'h78;

	// --------------------------------------------------------------
	// link pattern detection
	// --------------------------------------------------------------
	localparam hef_byte_t FLAG_OCTET = 8'h7E;
	localparam logic [2:0] ONES_BEFORE_ABORT = 3'h6;
	localparam logic [2:0] ONES_SAT = 3'h7;

	// --------------------------------------------------------------
	// bus answers
	// --------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {HEF_RD_IDLE, HEF_RD_RESP} hef_rd_state_e;

	// one-cycle event strobes from the HDLC engines
	typedef struct packed {
		logic tx_begin;
		logic rx_begin;
		logic tx_finish;
		logic rx_msg_done;
		logic rx_buf_full;
		logic fcs_fault;
	} hef_events_s;

	// incoming data-link bit stream
	typedef struct packed {
		logic valid;
		logic data;
	} hef_serial_s;

endpackage

// file: hef_event_flags_tb.sv
// self-checking testbench for the link-3 event flag block
`timescale 1ns/1ns
`default_nettype none

module hef_event_flags_tb;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	hef_pkg::hef_addr_t AWADDR = '0, ARADDR = '0;
	hef_pkg::hef_data_t WDATA = '0, RDATA;
	logic [3:0] WSTRB = '0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [3:0] strb = 4'hF;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic [1:0] BRESP, RRESP;
	hef_pkg::hef_events_s EVENTS = '0;
	hef_pkg::hef_serial_s RX_LINE = '0;
	int failures = 0;
	int cmp_count = 0;
	logic [1:0] exp_b[$], exp_rr[$];
	logic [31:0] exp_rd[$];
	// status seen per event, struct order msb first
	logic [7:0] ev_stat[6] = '{8'h40, 8'h20, 8'h10, 8'h09, 8'h08, 8'h04};
	logic [7:0] d;

	always #50 CLK = ~CLK;

	hef_event_flags dut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.EVENTS(EVENTS), .RX_LINE(RX_LINE), .IRQ(IRQ));

	// --------------------------------------------------------------
	// reporting
	// --------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cmp_data(input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] rdata expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_irq(input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] irq expected %b seen %b", e, s);
		end
	endtask

	task automatic hang();
		failures++;
		conclude();
	endtask

	// --------------------------------------------------------------
	// bus master; handshakes judged on settled values mid-cycle
	// --------------------------------------------------------------
	task automatic wr(input hef_pkg::hef_addr_t a, input logic [7:0] v, input logic [1:0] r);
		logic aw, w, b;
		exp_b.push_back(r);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= {24'h0, v};
		WSTRB <= strb;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge CLK);
			aw = AWVALID && AWREADY;
			w = WVALID && WREADY;
			b = BVALID && BREADY;
			@(posedge CLK);
			if (aw) AWVALID <= 1'b0;
			if (w) WVALID <= 1'b0;
			if (b) begin
				BREADY <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic rd(input hef_pkg::hef_addr_t a, input logic [7:0] v, input logic [1:0] r);
		logic ar, rv;
		exp_rd.push_back({24'h0, v});
		exp_rr.push_back(r);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge CLK);
			ar = ARVALID && ARREADY;
			rv = RVALID && RREADY;
			@(posedge CLK);
			if (ar) ARVALID <= 1'b0;
			if (rv) begin
				RREADY <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	// results taken off the queues as they appear
	always @(negedge CLK) begin
		if (BVALID && BREADY) cmp_resp("bresp", exp_b.pop_front(), BRESP);
		if (RVALID && RREADY) begin
			cmp_data(exp_rd.pop_front(), RDATA);
			cmp_resp("rresp", exp_rr.pop_front(), RRESP);
		end
	end

	task automatic pulse(input logic [5:0] v);
		@(posedge CLK) EVENTS <= v;
		@(posedge CLK) EVENTS <= '0;
		@(posedge CLK);
	endtask

	task automatic irq_is(input logic e);
		@(negedge CLK);
		cmp_irq(e, IRQ);
	endtask

	task automatic send(input logic [7:0] v, input int nb);
		for (int i = nb - 1; i >= 0; i--) begin
			@(posedge CLK) RX_LINE <= {1'b1, v[i]};
		end
		@(posedge CLK) RX_LINE <= '0;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		void'($urandom(14));
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		rd(hef_pkg::OFF_IRQ_EN, 8'h00, hef_pkg::RESP_OKAY);
		rd(hef_pkg::OFF_STATUS, 8'h00, hef_pkg::RESP_OKAY);
		wr(hef_pkg::OFF_IRQ_EN, 8'hFF, hef_pkg::RESP_OKAY);
		rd(hef_pkg::OFF_IRQ_EN, 8'h78, hef_pkg::RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(hef_pkg::OFF_IRQ_EN, d, hef_pkg::RESP_OKAY);
			rd(hef_pkg::OFF_IRQ_EN, d & 8'h78, hef_pkg::RESP_OKAY);
		end
		$display("test registers done");
		wr(8'h10, 8'hFF, hef_pkg::RESP_SLVERR);
		rd(8'h10, 8'h00, hef_pkg::RESP_SLVERR);
		$display("test unmapped done");
		for (int k = 0; k < 6; k++) begin
			// other enables on: this event alone must stay quiet
			wr(hef_pkg::OFF_IRQ_EN, ~ev_stat[k] & 8'h78, hef_pkg::RESP_OKAY);
			pulse(6'h20 >> k);
			irq_is(1'b0);
			rd(hef_pkg::OFF_STATUS, ev_stat[k], hef_pkg::RESP_OKAY);
			rd(hef_pkg::OFF_STATUS, 8'h00, hef_pkg::RESP_OKAY);
			wr(hef_pkg::OFF_IRQ_EN, 8'h78, hef_pkg::RESP_OKAY);
			pulse(6'h20 >> k);
			irq_is((ev_stat[k] & 8'h78) != 8'h00);
			rd(hef_pkg::OFF_STATUS, ev_stat[k], hef_pkg::RESP_OKAY);
			@(posedge CLK);
			irq_is(1'b0);
		end
		$display("test events done");
		wr(hef_pkg::OFF_STATUS, 8'hFF, hef_pkg::RESP_OKAY);
		rd(hef_pkg::OFF_STATUS, 8'h00, hef_pkg::RESP_OKAY);
		send(8'h7E, 8);
		rd(hef_pkg::OFF_STATUS, 8'h01, hef_pkg::RESP_OKAY);
		send(8'hFF, 6);
		rd(hef_pkg::OFF_STATUS, 8'h00, hef_pkg::RESP_OKAY);
		send(8'hFF, 1);
		send(8'h00, 1);
		rd(hef_pkg::OFF_STATUS, 8'h02, hef_pkg::RESP_OKAY);
		$display("test link done");
		// byte lane 0 off: the enable write must be dropped
		strb = 4'hE;
		wr(hef_pkg::OFF_IRQ_EN, 8'h00, hef_pkg::RESP_OKAY);
		strb = 4'hF;
		rd(hef_pkg::OFF_IRQ_EN, 8'h78, hef_pkg::RESP_OKAY);
		$display("test strobe done");
		pulse(6'h20);
		irq_is(1'b1);
		@(posedge CLK) RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		irq_is(1'b0);
		repeat (2) @(posedge CLK);
		rd(hef_pkg::OFF_IRQ_EN, 8'h00, hef_pkg::RESP_OKAY);
		rd(hef_pkg::OFF_STATUS, 8'h00, hef_pkg::RESP_OKAY);
		$display("test reset done");
		repeat (3) @(posedge CLK);
		conclude();
	end
endmodule

`default_nettype wire
